// ==== verilog/tria_access.sv ====
// Command/status register bridge to the timing receiver's internal registers.
// Assumes command writes come from logic on clk_i and the bus pins are open drain.
`include "tria_defs.svh"
module tria_access #(
    parameter logic [5:0] BASE_ID = `TRIA_BASE_ID,
    parameter int QTR_CYCLES = `TRIA_QTR_NS / `TRIA_CLK_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_wr_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic [15:0] command_o,
    output logic [15:0] status_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    tria_pkg::tria_seq_t state; // Sequencer state
    logic [2:0] step; // Transaction step
    logic [15:0] command; // Command register
    logic [7:0] rdata; // Last byte read
    logic busy; // Transfer underway
    logic err; // Bus error seen
    logic [5:0] base_id; // Receiver identifier, loaded by reset
    logic [7:0] txn_data; // Latched at launch so later writes cannot corrupt a transfer
    logic [4:0] txn_reg;
    logic txn_wr;
    logic abort, launch, last_done;
    logic eng_done, eng_nack;
    logic [7:0] eng_rx;
    tria_pkg::tria_op_t cur_op;

    // Step to primitive
    function automatic tria_pkg::tria_op_t step_op(input logic [2:0] s, input logic wr);
        case (s)
            `TRIA_STEP_PTR_START, `TRIA_STEP_DAT_START: step_op = tria_pkg::OP_START;
            `TRIA_STEP_PTR_STOP, `TRIA_STEP_DAT_STOP: step_op = tria_pkg::OP_STOP;
            `TRIA_STEP_DAT_BYTE: step_op = wr ? tria_pkg::OP_WRITE : tria_pkg::OP_READ;
            default: step_op = tria_pkg::OP_WRITE;
        endcase
    endfunction

    // Step to byte: pointer address, register number, data address, data
    function automatic logic [7:0] step_byte(input logic [2:0] s, input logic [5:0] id,
                                             input logic [4:0] r, input logic [7:0] d, input logic wr);
        case (s)
            `TRIA_STEP_PTR_ADDR: step_byte = {id, 1'b0, 1'b0};
            `TRIA_STEP_PTR_REG: step_byte = {3'h0, r};
            `TRIA_STEP_DAT_ADDR: step_byte = {id, 1'b1, !wr};
            default: step_byte = d;
        endcase
    endfunction

    assign abort = cmd_wr_i && cmd_wdata_i[`TRIA_CMD_RESET_BIT];
    assign launch = cmd_wr_i && !abort && !busy;
    assign last_done = (state == tria_pkg::S_WAIT) && eng_done && (step == `TRIA_STEP_DAT_STOP);
    assign cur_op = step_op(step, txn_wr);

    // Command register: every write is stored, even while busy
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            command <= `TRIA_CMD_RESET_VAL;
        end else if (cmd_wr_i) begin
            command <= cmd_wdata_i;
        end
    end
    assign command_o = command;

    // Base identifier: a constant taken at reset, never written
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            base_id <= BASE_ID;
        end
    end

    // Transaction fields latched at launch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            txn_data <= `TRIA_BYTE_RESET_VAL;
            txn_reg <= 5'h00;
            txn_wr <= 1'b0;
        end else if (launch) begin
            txn_data <= cmd_wdata_i[`TRIA_CMD_DATA_MSB:`TRIA_CMD_DATA_LSB];
            txn_reg <= cmd_wdata_i[`TRIA_CMD_REG_MSB:`TRIA_CMD_REG_LSB];
            txn_wr <= cmd_wdata_i[`TRIA_CMD_WRITE_BIT];
        end
    end

    // Sequencer; a refused acknowledge skips to the final stop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= tria_pkg::S_IDLE;
            step <= `TRIA_STEP_PTR_START;
        end else if (abort) begin
            state <= tria_pkg::S_IDLE;
            step <= `TRIA_STEP_PTR_START;
        end else begin
            unique case (state)
                tria_pkg::S_IDLE: begin
                    if (launch) begin
                        state <= tria_pkg::S_ISSUE;
                        step <= `TRIA_STEP_PTR_START;
                    end
                end
                tria_pkg::S_ISSUE: state <= tria_pkg::S_WAIT;
                tria_pkg::S_WAIT: begin
                    if (eng_done) begin
                        if (step == `TRIA_STEP_DAT_STOP) begin
                            state <= tria_pkg::S_IDLE;
                        end else if (eng_nack && cur_op == tria_pkg::OP_WRITE) begin
                            state <= tria_pkg::S_ISSUE;
                            step <= `TRIA_STEP_DAT_STOP;
                        end else begin
                            state <= tria_pkg::S_ISSUE;
                            step <= step + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Busy flag: set at launch, cleared once the final stop is out
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
        end else if (abort) begin
            busy <= 1'b0;
        end else if (launch) begin
            busy <= 1'b1;
        end else if (last_done) begin
            busy <= 1'b0;
        end
    end

    // Error flag: a refused acknowledge on any written byte; a new launch clears it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            err <= 1'b0;
        end else if (abort) begin
            err <= 1'b0;
        end else if (state == tria_pkg::S_WAIT && eng_done && eng_nack && cur_op == tria_pkg::OP_WRITE) begin
            err <= 1'b1;
        end else if (launch) begin
            err <= 1'b0;
        end
    end

    // Read byte captured only when the whole byte is in
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata <= `TRIA_BYTE_RESET_VAL;
        end else if (abort) begin
            rdata <= `TRIA_BYTE_RESET_VAL;
        end else if (state == tria_pkg::S_WAIT && eng_done && cur_op == tria_pkg::OP_READ) begin
            rdata <= eng_rx;
        end
    end

    // Status word
    always_comb begin
        status_o = 16'h0000;
        status_o[`TRIA_STAT_DATA_MSB:`TRIA_STAT_DATA_LSB] = rdata;
        status_o[`TRIA_STAT_BUSY_BIT] = busy;
        status_o[`TRIA_STAT_ERR_BIT] = err;
    end

    // Bus primitives; the single read byte ends with a master not-acknowledge
    tria_bit_engine #(
        .QTR_CYCLES(QTR_CYCLES)
    ) u_engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .abort_i(abort),
        .go_i(state == tria_pkg::S_ISSUE),
        .op_i(cur_op),
        .tx_byte_i(step_byte(step, base_id, txn_reg, txn_data, txn_wr)),
        .master_ack_i(1'b0),
        .done_o(eng_done),
        .rx_byte_o(eng_rx),
        .nack_o(eng_nack),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe_o(scl_oe_o),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o)
    );

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_launch;
        cmd_wr_i && !cmd_wdata_i[`TRIA_CMD_RESET_BIT] && !busy;
    endsequence
    sequence s_abort;
        cmd_wr_i && cmd_wdata_i[`TRIA_CMD_RESET_BIT];
    endsequence

    property p_launch;
        s_launch |=> status_o[`TRIA_STAT_BUSY_BIT] && state == tria_pkg::S_ISSUE;
    endproperty
    a_launch: assert property (p_launch) else $error("write while idle did not start a transfer");

    property p_abort;
        s_abort |=> !status_o[`TRIA_STAT_BUSY_BIT] && !scl_oe_o && !sda_oe_o && state == tria_pkg::S_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("reset bit did not abort the transfer");

    property p_power_up;
        $fell(rst_i) |-> command_o == `TRIA_CMD_RESET_VAL && status_o == 16'h0000;
    endproperty
    a_power_up: assert property (p_power_up) else $error("registers not clear after reset");

    // The byte sent is the one written with the launching command, not any later command
    property p_wdata;
        s_launch |=> txn_data == $past(cmd_wdata_i[`TRIA_CMD_DATA_MSB:`TRIA_CMD_DATA_LSB]);
    endproperty
    a_wdata: assert property (p_wdata) else $error("write byte differs from command");

    property p_regno;
        s_launch |=> txn_reg == $past(cmd_wdata_i[`TRIA_CMD_REG_MSB:`TRIA_CMD_REG_LSB])
            && txn_wr == $past(cmd_wdata_i[`TRIA_CMD_WRITE_BIT]);
    endproperty
    a_regno: assert property (p_regno) else $error("register number or direction not latched");

    property p_dir;
        state == tria_pkg::S_ISSUE && step == `TRIA_STEP_DAT_BYTE |-> (cur_op == tria_pkg::OP_WRITE) == txn_wr;
    endproperty
    a_dir: assert property (p_dir) else $error("direction does not follow bit 13");

    property p_rdata;
        $changed(rdata) |-> $past(abort) || ($past(eng_done) && $past(cur_op) == tria_pkg::OP_READ);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read byte changed outside read completion");

    property p_busy_hold;
        s_launch |=> status_o[`TRIA_STAT_BUSY_BIT] [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_err;
        state == tria_pkg::S_WAIT && eng_done && eng_nack && cur_op == tria_pkg::OP_WRITE && !abort
            |=> status_o[`TRIA_STAT_ERR_BIT] ##1 step == `TRIA_STEP_DAT_STOP;
    endproperty
    a_err: assert property (p_err) else $error("refused acknowledge not flagged");

    property p_base;
        state == tria_pkg::S_ISSUE && step == `TRIA_STEP_PTR_ADDR |-> base_id == `TRIA_BASE_ID && $stable(base_id);
    endproperty
    a_base: assert property (p_base) else $error("base identifier changed");

    property p_busy_write;
        busy && cmd_wr_i && !cmd_wdata_i[`TRIA_CMD_RESET_BIT] |=> $stable(txn_reg) && $stable(txn_data);
    endproperty
    a_busy_write: assert property (p_busy_write) else $error("write while busy altered transfer");

    property p_busy_end;
        $fell(busy) && !$past(abort) |-> $past(eng_done) && $past(step) == `TRIA_STEP_DAT_STOP;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy cleared before final stop");
endmodule

// ==== verilog/tria_defs.svh ====
// Constants for the timing receiver register access bridge.
// Assumes a 100 MHz module clock and a 100 kHz I2C bus.
`ifndef TRIA_DEFS_SVH
`define TRIA_DEFS_SVH

// Command register fields
`define TRIA_CMD_DATA_LSB 0
`define TRIA_CMD_DATA_MSB 7
`define TRIA_CMD_REG_LSB 8
`define TRIA_CMD_REG_MSB 12
`define TRIA_CMD_WRITE_BIT 13
`define TRIA_CMD_RESET_BIT 15
// Status register fields
`define TRIA_STAT_DATA_LSB 0
`define TRIA_STAT_DATA_MSB 7
`define TRIA_STAT_BUSY_BIT 13
`define TRIA_STAT_ERR_BIT 14
// Power-up values
`define TRIA_CMD_RESET_VAL 16'h0000
`define TRIA_BYTE_RESET_VAL 8'h00
// Receiver base identifier loaded at reset
`define TRIA_BASE_ID 6'h04
// Timing: module clock period and quarter of an I2C bit, in ns
`define TRIA_CLK_NS 10
`define TRIA_QTR_NS 2500
// Transaction steps
`define TRIA_STEP_PTR_START 3'h0
`define TRIA_STEP_PTR_ADDR 3'h1
`define TRIA_STEP_PTR_REG 3'h2
`define TRIA_STEP_PTR_STOP 3'h3
`define TRIA_STEP_DAT_START 3'h4
`define TRIA_STEP_DAT_ADDR 3'h5
`define TRIA_STEP_DAT_BYTE 3'h6
`define TRIA_STEP_DAT_STOP 3'h7
// Bit positions inside one I2C bit, and bits per byte plus acknowledge
`define TRIA_PH_LOW 2'h0
`define TRIA_PH_RISE 2'h1
`define TRIA_PH_HIGH 2'h2
`define TRIA_PH_FALL 2'h3
`define TRIA_LAST_BIT 4'h8

`endif

// ==== verilog/tria_pkg.sv ====
// Types shared by the access bridge and its bit engine.
// Assumes tria_defs.svh holds the numeric constants.
package tria_pkg;
    // Bus primitives the sequencer asks of the bit engine
    typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} tria_op_t;
    // Sequencer states
    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} tria_seq_t;
    // Bit engine states
    typedef enum logic {E_IDLE, E_RUN} tria_eng_t;
endpackage

// ==== verilog/tria_bit_engine.sv ====
// I2C bit engine: start, stop, byte write and byte read on open-drain pins.
// Assumes one go pulse at a time, only while done is not pending.
`include "tria_defs.svh"
module tria_bit_engine #(
    parameter int QTR_CYCLES = 250
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic abort_i,
    input wire logic go_i,
    input wire tria_pkg::tria_op_t op_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic master_ack_i,
    output logic done_o,
    output logic [7:0] rx_byte_o,
    output logic nack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    localparam int CW = $clog2(QTR_CYCLES);
    localparam logic [CW-1:0] QTR_LAST = CW'(QTR_CYCLES - 1);

    // The counter needs at least two states to pace the bus
    generate
        if (QTR_CYCLES < 2) begin : g_bad
            $error("QTR_CYCLES must be at least 2");
        end
    endgenerate

    tria_pkg::tria_eng_t state; // Idle or shifting
    tria_pkg::tria_op_t op; // Primitive in flight
    logic [CW-1:0] cnt; // Quarter-bit divider
    logic [1:0] phase; // Quarter inside the bit
    logic [3:0] bitn; // Bit number, 8 is acknowledge
    logic [7:0] sh; // Shift register
    logic samp; // SDA level taken while SCL is high
    logic scl_m, scl_s, sda_m, sda_s; // Pin synchronisers
    logic tick; // Quarter-bit enable
    logic adv; // Phase advance, held off by a stretched SCL
    logic [1:0] drv; // {scl_low, sda_low} for the current phase

    // Open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Two flops on each pin; only the second stage is read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
        end
    end

    // Divider: free running while a primitive is in flight
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (abort_i || state == tria_pkg::E_IDLE || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
    assign tick = (state == tria_pkg::E_RUN) && (cnt == QTR_LAST);
    // A slave holding SCL low stretches the rise phase
    assign adv = tick && (phase != `TRIA_PH_RISE || scl_s);

    // Pin levels per primitive and phase
    function automatic logic [1:0] drive(input tria_pkg::tria_op_t o, input logic [1:0] p,
                                         input logic [3:0] b, input logic [7:0] s, input logic mack);
        logic outbit;
        outbit = 1'b1;
        unique case (o)
            tria_pkg::OP_START: drive = {p >= `TRIA_PH_HIGH, p != `TRIA_PH_LOW};
            tria_pkg::OP_STOP: drive = {p == `TRIA_PH_LOW, p <= `TRIA_PH_RISE};
            default: begin
                if (b == `TRIA_LAST_BIT) begin
                    outbit = (o == tria_pkg::OP_READ) ? !mack : 1'b1;
                end else begin
                    outbit = (o == tria_pkg::OP_WRITE) ? s[7] : 1'b1;
                end
                drive = {p == `TRIA_PH_LOW || p == `TRIA_PH_FALL, !outbit};
            end
        endcase
    endfunction
    assign drv = drive(op, phase, bitn, sh, master_ack_i);

    // Sequencing of phases and bits
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= tria_pkg::E_IDLE;
            op <= tria_pkg::OP_STOP;
            phase <= `TRIA_PH_LOW;
            bitn <= 4'h0;
            sh <= `TRIA_BYTE_RESET_VAL;
            samp <= 1'b1;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                state <= tria_pkg::E_IDLE;
            end else if (state == tria_pkg::E_IDLE) begin
                if (go_i) begin
                    state <= tria_pkg::E_RUN;
                    op <= op_i;
                    phase <= `TRIA_PH_LOW;
                    bitn <= 4'h0;
                    sh <= tx_byte_i;
                end
            end else if (adv) begin
                phase <= phase + 2'h1;
                if (phase == `TRIA_PH_HIGH) begin
                    samp <= sda_s;
                end
                if (phase == `TRIA_PH_FALL) begin
                    if (op == tria_pkg::OP_START || op == tria_pkg::OP_STOP || bitn == `TRIA_LAST_BIT) begin
                        state <= tria_pkg::E_IDLE;
                        done_o <= 1'b1;
                    end else begin
                        sh <= {sh[6:0], samp};
                        bitn <= bitn + 4'h1;
                    end
                end
            end
        end
    end

    // Results: the acknowledge bit and the shifted byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nack_o <= 1'b0;
            rx_byte_o <= `TRIA_BYTE_RESET_VAL;
        end else if (adv && phase == `TRIA_PH_FALL && bitn == `TRIA_LAST_BIT) begin
            nack_o <= samp;
            rx_byte_o <= sh;
        end
    end

    // Registered pin drive; idle holds the last level, so SCL stays low after a start or a byte and is released after a stop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (abort_i) begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (state == tria_pkg::E_RUN) begin
            scl_oe_o <= drv[1];
            sda_oe_o <= drv[0];
        end
    end
endmodule

// ==== tb/tria_rx_model.sv ====
// Behavioural timing receiver on the I2C pins: byte registers, pointer write, data write and read.
// Assumes the bench resolves both open-drain wires with pull-ups and feeds the levels back here.
module tria_rx_model #(
    parameter logic [5:0] BASE_ID = 6'h04
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic refuse_i,
    input wire logic stretch_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [0:31]; // Byte registers, indexed by register number
    logic [7:0] sh; // Byte shifted in from the master
    logic [7:0] out; // Byte being returned
    logic [4:0] ptr; // Register pointer set by the pointer write
    logic active; // Inside a frame
    logic reading; // Returning a data byte
    logic datamode; // Addressed at the data address
    logic rd; // Direction bit of the address byte
    int cnt; // Rising SCL edges in the current byte
    int byte_idx; // Bytes completed in the frame

    // Known contents stand in for delays, counters and address settings
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'(i * 7 + 3);
        end
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        active = 1'b0;
        reading = 1'b0;
    end

    // Start: data falls while the clock is high
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            active = 1'b1;
            cnt = 0;
            byte_idx = 0;
            reading = 1'b0;
        end
    end

    // Stop: data rises while the clock is high; let go of the data line
    always @(posedge sda_i) begin
        if (scl_i === 1'b1) begin
            active = 1'b0;
            sda_oe_o = 1'b0;
        end
    end

    // Sample master bits on the rising clock, MSB first
    always @(posedge scl_i) begin
        if (active) begin
            if (cnt < 8 && !reading) begin
                sh = {sh[6:0], sda_i};
            end
            cnt++;
        end
    end

    // Change our own data only while the clock is low
    always @(negedge scl_i) begin
        if (active && cnt == 8) begin
            sda_oe_o = 1'b0;
            if (!reading && byte_idx == 0) begin
                datamode = sh[1];
                rd = sh[0];
                sda_oe_o = (sh[7:2] == BASE_ID) && !refuse_i;
            end else if (!reading) begin
                if (!datamode) begin
                    ptr = sh[4:0];
                end else if (!rd) begin
                    regs[ptr] = sh;
                end
                sda_oe_o = 1'b1;
            end
            // A slow receiver holds the clock low over the acknowledge slot
            if (stretch_i) begin
                scl_oe_o = 1'b1;
                #300;
                scl_oe_o = 1'b0;
            end
        end else if (active && cnt == 9) begin
            // Only the byte after a read address is returned; afterwards the master stops
            reading = (byte_idx == 0) && rd && datamode;
            out = regs[ptr];
            cnt = 0;
            byte_idx++;
            sda_oe_o = reading && !out[7];
        end else if (active && reading && cnt < 8) begin
            sda_oe_o = !out[7 - cnt];
        end
    end
endmodule

// ==== tb/tria_access_bench.sv ====
// Self-checking bench for the timing receiver access bridge.
// Assumes tria_rx_model answers on the far side of the open-drain I2C pins.
`define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", name, exp, got); end end
module tria_access_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QTR = 4; // Short bit time keeps the run brief
    logic clk_i, rst_i, cmd_wr_i, scl_oe_o, sda_oe_o, m_scl_oe, m_sda_oe, refuse, stretch;
    logic [15:0] cmd_wdata_i, command_o, status_o;
    logic [1:0] pin_lvl; // Driven levels of the open-drain pins, must stay low
    wire logic scl = !(scl_oe_o || m_scl_oe); // Pull-up wins unless a party pulls low
    wire logic sda = !(sda_oe_o || m_sda_oe);
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [31:0] lfsr = 32'h0001111F; // Fixed seed
    logic [7:0] shadow [0:31]; // Bench view of the receiver registers
    logic [7:0] exp_data; // Expected read byte
    logic exp_err; // Expected error flag

    tria_access #(.QTR_CYCLES(QTR)) dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr_i),
        .cmd_wdata_i(cmd_wdata_i), .command_o(command_o), .status_o(status_o), .scl_i(scl), .scl_o(pin_lvl[1]),
        .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(pin_lvl[0]), .sda_oe_o(sda_oe_o));
    tria_rx_model model (.scl_i(scl), .sda_i(sda), .refuse_i(refuse), .stretch_i(stretch),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Expected status word from the bench model
    function automatic logic [15:0] stat(input logic busy);
        return {1'b0, exp_err, busy, 5'h00, exp_data};
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One-cycle write strobe; the register reads back on the next cycle
    task automatic wr_cmd(input logic [15:0] v);
        @(negedge clk_i);
        cmd_wr_i = 1'b1;
        cmd_wdata_i = v;
        @(negedge clk_i);
        cmd_wr_i = 1'b0;
        `CHK("command", v, command_o)
    endtask

    // Bounded poll of the busy flag
    task automatic wait_idle();
        int i;
        for (i = 0; i < 5000 && status_o[13] !== 1'b0; i++) begin
            @(negedge clk_i);
        end
        if (i == 5000) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    // Full transfer, compared at launch and at completion
    task automatic xfer(input logic [4:0] r, input logic [7:0] d, input logic wr);
        wr_cmd({2'b00, wr, r, d});
        exp_err = 1'b0;
        `CHK("launch", stat(1'b1), status_o)
        wait_idle();
        exp_err = refuse;
        if (!refuse && wr) begin
            shadow[r] = d;
        end else if (!refuse) begin
            exp_data = shadow[r];
        end
        `CHK("done", stat(1'b0), status_o)
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        cmd_wr_i = 1'b0;
        cmd_wdata_i = 16'h0000;
        refuse = 1'b0;
        stretch = 1'b0;
        exp_data = 8'h00;
        exp_err = 1'b0;
        for (int i = 0; i < 32; i++) begin
            shadow[i] = 8'(i * 7 + 3);
        end
        repeat (3) @(negedge clk_i);
        `CHK("reset command", 16'h0000, command_o)
        `CHK("reset status", 16'h0000, status_o)
        rst_i = 1'b0;
        // Random register, read old content, write random byte, read it back; some slow answers
        for (int k = 0; k < 6; k++) begin
            lfsr = lfsr_next(lfsr);
            stretch = lfsr[20];
            xfer(lfsr[12:8], 8'h00, 1'b0);
            xfer(lfsr[12:8], lfsr[7:0], 1'b1);
            xfer(lfsr[12:8], 8'h00, 1'b0);
        end
        stretch = 1'b0;
        // Second command while busy is stored but starts nothing
        wr_cmd(16'h23C3);
        wr_cmd(16'h233C);
        `CHK("refused", stat(1'b1), status_o)
        wait_idle();
        shadow[3] = 8'hC3;
        xfer(5'h03, 8'h00, 1'b0);
        // Refused acknowledge sets the error; next launch clears it
        refuse = 1'b1;
        xfer(5'h07, 8'h00, 1'b0);
        refuse = 1'b0;
        xfer(5'h07, 8'h00, 1'b0);
        // Soft reset in mid-transfer
        wr_cmd(16'h2511);
        repeat (100) @(negedge clk_i);
        wr_cmd(16'h8000);
        exp_data = 8'h00;
        exp_err = 1'b0;
        `CHK("abort status", stat(1'b0), status_o)
        @(negedge clk_i);
        `CHK("abort pins", 2'b00, {scl_oe_o, sda_oe_o})
        `CHK("pin levels", 2'b00, pin_lvl)
        xfer(5'h05, 8'h00, 1'b0);
        // Hard reset in mid-transfer
        wr_cmd(16'h0402);
        repeat (100) @(negedge clk_i);
        rst_i = 1'b1;
        @(negedge clk_i);
        `CHK("rerun command", 16'h0000, command_o)
        `CHK("rerun status", 16'h0000, status_o)
        rst_i = 1'b0;
        exp_data = 8'h00;
        xfer(5'h04, 8'h00, 1'b0);
        finish_test();
    end
endmodule
